/* rtl/adcsc_top.sv */
/*
 Sequencing control of a 10-bit successive approximation converter:
 enable, start, auto trigger, prescaler, done flag, interrupt request,
 locking result bytes and digital input disable, behind an APB slave.
 Assumes the analog core takes the active channel and reference, holds
 its result on conv_data_in when a conversion completes, and that all
 inputs are synchronous to sys_clk_in.
*/
// The address map and register access over APB were decided locally.
// What this block does
// RULE_01 - enable powers converter; clearing it turns off and aborts conversion
// RULE_02 - start write begins one conversion; free run starts only the first
// RULE_03 - first conversion after enable takes 25 converter clocks, later 13
// RULE_04 - start reads one while converting, zero after; writing zero ignored
// RULE_05 - auto trigger starts conversion on rising edge of chosen trigger
// RULE_06 - done flag set when conversion finishes and result is updated; here set on every completion, also while a lock keeps the result
// RULE_07 - interrupt requested only with flag, enable and global enable set
// RULE_08 - done flag cleared by interrupt acknowledge or by writing one
// RULE_09 - software avoids read-modify-write on control register A
// RULE_10 - prescaler codes 0..7 divide system clock by 2,2,4,..,128
// RULE_11 - after low byte read, result frozen until high byte read
// RULE_12 - software reads low byte before high byte for full precision
// RULE_13 - right or left alignment places result bits; unused bits zero
// RULE_14 - trigger source ignored unless auto trigger; flag rise triggers
// RULE_15 - switching to a set source makes an edge that starts conversion
// RULE_16 - selecting free running code never creates a trigger event
// RULE_17 - trigger codes select free run, comparator, int0, timers in order
// RULE_18 - software writes zero to reserved bit 7 of control register B
// RULE_19 - pin disable bit turns off input buffer, port bit reads zero
// RULE_20 - software disables digital input on unused analog pins
// RULE_21 - alignment change alters result presentation immediately
// RULE_22 - channel and reference changes wait for conversion completion
// RULE_23 - prescaler runs only when enabled and restarts from zero
// RULE_24 - free running restarts on the converter clock after completion
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_params.svh"

module adcsc_top
	import adcsc_pkg::*;
#(
	parameter int RESULT_W = 10,
	parameter int PIN_N    = 8
) (
	// clock and reset
	input  wire logic                sys_clk_in,
	input  wire logic                rst_in,
	// register bus
	input  wire adcsc_apb_t          apb_in,
	output logic [31:0]              prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out,
	// processor interrupt side
	input  wire logic                global_irq_enable_in,
	input  wire logic                irq_ack_in,
	output logic                     irq_out,
	// trigger flags, index = trigger code, bit 0 unused
	input  wire logic [7:0]          trig_flags_in,
	// analog core
	input  wire logic [RESULT_W-1:0] conv_data_in,
	output logic                     adc_power_out,
	output logic                     conv_active_out,
	output logic [4:0]               channel_select_out,
	output logic [1:0]               reference_select_out,
	// analog pins as digital inputs
	input  wire logic [PIN_N-1:0]    pin_raw_in,
	output logic [PIN_N-1:0]         port_pin_out,
	output logic [PIN_N-1:0]         pin_input_disable_out
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (RESULT_W != 10) begin : g_bad_res
		$error("result width must be 10");
	end
	if (PIN_N != 8) begin : g_bad_pin
		$error("pin count must be 8");
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic                en;
		logic                ate;
		logic                done;
		logic                ie;
		logic [2:0]          ps;
		logic                aux;
		logic [2:0]          ts;
		logic [7:0]          isel;
		logic [PIN_N-1:0]    pdis;
		logic [RESULT_W-1:0] res;
		logic                lock;
		logic                first;
		adcsc_fsm_t          fsm;
		logic [4:0]          cyc;
		logic [6:0]          pre;
		logic                trig_prev;
		logic [4:0]          act_chan;
		logic [1:0]          act_ref;
		logic                pready;
		logic                pslverr;
		logic [7:0]          prdata;
		logic                irq;
		logic [PIN_N-1:0]    pins;
	} adcsc_state_t;

	adcsc_state_t s_r;
	adcsc_state_t s_nxt;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic logic [6:0] div_m1(input logic [2:0] code);
		case (code)
			3'h0, 3'h1: div_m1 = 7'h01;
			3'h2:       div_m1 = 7'h03;
			3'h3:       div_m1 = 7'h07;
			3'h4:       div_m1 = 7'h0F;
			3'h5:       div_m1 = 7'h1F;
			3'h6:       div_m1 = 7'h3F;
			default:    div_m1 = 7'h7F;
		endcase
	endfunction

	function automatic logic [4:0] conv_last(input logic first);
		conv_last = first ? (`ADCSC_CONV_FIRST - 5'd1)
		                  : (`ADCSC_CONV_NORM - 5'd1);
	endfunction

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == `ADCSC_OFF_CTLA) || (a == `ADCSC_OFF_CTLB) ||
		          (a == `ADCSC_OFF_ISEL) || (a == `ADCSC_OFF_RESLO) ||
		          (a == `ADCSC_OFF_RESHI) || (a == `ADCSC_OFF_PDIS);
	endfunction

	// alignment is applied at read time so a change shows at once
	function automatic logic [7:0] res_lo(input logic [9:0] r,
	                                      input logic left);
		res_lo = left ? {r[1:0], 6'h00} : r[7:0];
	endfunction

	function automatic logic [7:0] res_hi(input logic [9:0] r,
	                                      input logic left);
		res_hi = left ? r[9:2] : {6'h00, r[9:8]};
	endfunction

	// ------------------------------------------------------------
	// bus decode and events
	// ------------------------------------------------------------
	logic       acc;
	logic       wr;
	logic       rd;
	logic [7:0] wd;
	logic [7:0] addr;
	logic       tick;
	logic       complete;
	logic       trig_sel;
	logic       trig_go;
	logic       wr_ctla;
	logic [7:0] rd_val;

	assign addr = apb_in.paddr;
	assign wd   = apb_in.pwdata[7:0];
	assign acc  = apb_in.psel & apb_in.penable & s_r.pready;
	assign wr   = acc & apb_in.pwrite & reg_hit(addr);
	assign rd   = acc & ~apb_in.pwrite & reg_hit(addr);
	assign wr_ctla = wr && (addr == `ADCSC_OFF_CTLA);

	assign tick = s_r.en && (s_r.pre == div_m1(s_r.ps));  // [RULE_10]
	assign complete = tick && (s_r.fsm == CV_RUN) &&
	                  (s_r.cyc == conv_last(s_r.first));  // [RULE_03]

	// free running code selects a constant low level, so no edge [RULE_16]
	assign trig_sel = (s_r.ts == `ADCSC_TS_FREE) ? 1'b0
	                : trig_flags_in[s_r.ts];              // [RULE_17]
	assign trig_go = s_r.ate & trig_sel & ~s_r.trig_prev &
	                 s_r.en & (s_r.fsm == CV_IDLE);       // [RULE_05] [RULE_14] [RULE_15]

	always_comb begin
		case (addr)
			`ADCSC_OFF_CTLA:  rd_val = {s_r.en, s_r.fsm != CV_IDLE,
			                            s_r.ate, s_r.done, s_r.ie,
			                            s_r.ps};          // [RULE_04]
			`ADCSC_OFF_CTLB:  rd_val = {1'b0, s_r.aux, 3'h0, s_r.ts};
			`ADCSC_OFF_ISEL:  rd_val = s_r.isel;
			`ADCSC_OFF_RESLO: rd_val = res_lo(s_r.res,
			                                  s_r.isel[`ADCSC_B_LEFT]); // [RULE_13] [RULE_21]
			`ADCSC_OFF_RESHI: rd_val = res_hi(s_r.res,
			                                  s_r.isel[`ADCSC_B_LEFT]); // [RULE_13]
			`ADCSC_OFF_PDIS:  rd_val = s_r.pdis;
			default:          rd_val = `ADCSC_RST_BYTE;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// one wait state, then answer
		s_nxt.pready  = apb_in.psel & apb_in.penable & ~s_r.pready;
		s_nxt.pslverr = s_nxt.pready & ~reg_hit(addr);
		s_nxt.prdata  = (s_nxt.pready && !apb_in.pwrite) ? rd_val
		                                                 : `ADCSC_RST_BYTE;
		s_nxt.trig_prev = trig_sel;
		s_nxt.pins = pin_raw_in & ~s_r.pdis;                 // [RULE_19]
		s_nxt.irq  = s_r.done & s_r.ie & global_irq_enable_in; // [RULE_07]

		if (!s_r.en || tick) begin
			s_nxt.pre = 7'h00;                           // [RULE_23]
		end else begin
			s_nxt.pre = s_r.pre + 7'h01;
		end

		case (s_r.fsm)
			CV_IDLE: begin
				if (trig_go) begin
					s_nxt.fsm = CV_WAIT;
				end
			end
			CV_WAIT: begin
				if (tick) begin
					s_nxt.fsm = CV_RUN;
					s_nxt.cyc = 5'h00;
				end
			end
			CV_RUN: begin
				if (complete) begin
					s_nxt.cyc   = 5'h00;
					s_nxt.first = 1'b0;
					if (!s_r.lock) begin
						s_nxt.res = conv_data_in;    // [RULE_11]
					end
					// back-to-back restart in free running [RULE_24]
					if (s_r.ate && s_r.ts == `ADCSC_TS_FREE) begin
						s_nxt.fsm = CV_RUN;
					end else begin
						s_nxt.fsm = CV_IDLE;
					end
				end else if (tick) begin
					s_nxt.cyc = s_r.cyc + 5'h01;
				end
			end
			default: begin
				s_nxt.fsm = CV_IDLE;
			end
		endcase

		// selection only follows the register between conversions
		if (s_r.fsm != CV_RUN || complete) begin
			s_nxt.act_chan = s_r.isel[4:0];              // [RULE_22]
			s_nxt.act_ref  = s_r.isel[7:6];
		end

		// a completion in the same cycle as a clear keeps the flag
		if (complete) begin
			s_nxt.done = 1'b1;                           // [RULE_06]
		end else if (irq_ack_in || (wr_ctla && wd[`ADCSC_B_DONE])) begin
			s_nxt.done = 1'b0;                           // [RULE_08]
		end

		if (rd && addr == `ADCSC_OFF_RESLO) begin
			s_nxt.lock = 1'b1;                           // [RULE_11]
		end else if (rd && addr == `ADCSC_OFF_RESHI) begin
			s_nxt.lock = 1'b0;
		end

		if (wr) begin
			case (addr)
				`ADCSC_OFF_CTLA: begin
					s_nxt.en  = wd[`ADCSC_B_EN];         // [RULE_01]
					s_nxt.ate = wd[`ADCSC_B_ATE];
					s_nxt.ie  = wd[`ADCSC_B_IE];
					s_nxt.ps  = wd[2:0];
					if (wd[`ADCSC_B_EN] && !s_r.en) begin
						s_nxt.first = 1'b1;          // [RULE_03]
						s_nxt.pre   = 7'h00;         // [RULE_23]
					end
					if (!wd[`ADCSC_B_EN]) begin
						s_nxt.fsm = CV_IDLE;         // [RULE_01]
						s_nxt.cyc = 5'h00;
					end else if (wd[`ADCSC_B_START] &&
					             s_r.fsm == CV_IDLE) begin
						s_nxt.fsm = CV_WAIT;         // [RULE_02] [RULE_04]
					end
				end
				`ADCSC_OFF_CTLB: begin
					s_nxt.aux = wd[`ADCSC_B_AUX];
					s_nxt.ts  = wd[2:0];
				end
				`ADCSC_OFF_ISEL: begin
					s_nxt.isel = wd;
				end
				`ADCSC_OFF_PDIS: begin
					s_nxt.pdis = wd;
				end
				default: begin
					s_nxt.isel = s_r.isel;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata_out            = {24'h000000, s_r.prdata};
	assign pready_out            = s_r.pready;
	assign pslverr_out           = s_r.pslverr;
	assign irq_out               = s_r.irq;
	assign adc_power_out         = s_r.en;
	assign conv_active_out       = s_r.fsm[1];
	assign channel_select_out    = s_r.act_chan;
	assign reference_select_out  = s_r.act_ref;
	assign port_pin_out          = s_r.pins;
	assign pin_input_disable_out = s_r.pdis;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_disable_aborts: assert property ( // [RULE_01]
		wr_ctla && !wd[`ADCSC_B_EN] |=> s_r.fsm == CV_IDLE && !s_r.en)
		else $error("disable did not abort conversion");

	a_start_write: assert property ( // [RULE_02]
		wr_ctla && wd[`ADCSC_B_EN] && wd[`ADCSC_B_START] &&
		s_r.fsm == CV_IDLE |=> s_r.fsm == CV_WAIT)
		else $error("start write did not start conversion");

	a_conv_length: assert property ( // [RULE_03]
		complete |-> s_r.cyc == (s_r.first ? 5'h18 : 5'h0C))
		else $error("conversion length wrong");

	// the count never runs past the last converter clock of its run
	a_conv_bound: assert property ( // [RULE_03]
		s_r.fsm == CV_RUN |-> s_r.cyc <= (s_r.first ? 5'h18 : 5'h0C))
		else $error("conversion count overran");

	a_done_set: assert property ( // [RULE_06]
		complete |=> s_r.done)
		else $error("done flag not set on completion");

	a_irq_gate: assert property ( // [RULE_07]
		irq_out |-> $past(s_r.done) && $past(s_r.ie) &&
		$past(global_irq_enable_in))
		else $error("interrupt without all enables");

	a_ack_clears: assert property ( // [RULE_08]
		irq_ack_in && !complete |=> !s_r.done)
		else $error("acknowledge did not clear done flag");

	a_tick_rate: assert property ( // [RULE_10]
		tick |=> !tick [*1] ##0 s_r.pre == 7'h00)
		else $error("prescaler did not restart after tick");

	a_lock_hold: assert property ( // [RULE_11]
		s_r.lock && !(rd && addr == `ADCSC_OFF_RESHI) |=> $stable(s_r.res))
		else $error("result changed while locked");

	a_free_no_trig: assert property ( // [RULE_16]
		s_r.ts == `ADCSC_TS_FREE && s_r.fsm == CV_IDLE && !wr_ctla
		|=> s_r.fsm == CV_IDLE)
		else $error("free running code produced a trigger");

	a_pins_masked: assert property ( // [RULE_19]
		##1 port_pin_out == ($past(pin_raw_in) & ~$past(s_r.pdis)))
		else $error("disabled pin did not read zero");

	a_pre_idle: assert property ( // [RULE_23]
		!s_r.en |=> s_r.pre == 7'h00)
		else $error("prescaler ran while disabled");

endmodule
`default_nettype wire

/* common/adcsc_params.svh */
/*
 Offsets, field positions, reset values and cycle counts of the
 converter sequencing control block.
 Assumes inclusion through its bare name; definitions only.
*/
`ifndef ADCSC_PARAMS_SVH
`define ADCSC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets on the bus
// ----------------------------------------------------------------
`define ADCSC_OFF_CTLA     8'h00
`define ADCSC_OFF_CTLB     8'h04
`define ADCSC_OFF_ISEL     8'h08
`define ADCSC_OFF_RESLO    8'h0C
`define ADCSC_OFF_RESHI    8'h10
`define ADCSC_OFF_PDIS     8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCSC_B_EN         7
`define ADCSC_B_START      6
`define ADCSC_B_ATE        5
`define ADCSC_B_DONE       4
`define ADCSC_B_IE         3
`define ADCSC_B_AUX        6
`define ADCSC_B_LEFT       5

// ----------------------------------------------------------------
// reset values and conversion lengths in converter clocks
// ----------------------------------------------------------------
`define ADCSC_RST_BYTE     8'h00
`define ADCSC_TS_FREE      3'h0
`define ADCSC_CONV_FIRST   5'h19
`define ADCSC_CONV_NORM    5'h0D

`endif

/* common/adcsc_pkg.sv */
/*
 Types of the converter sequencing control block.
 Assumes nothing of its surroundings.
*/
package adcsc_pkg;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_WAIT = 2'b01,
		CV_RUN  = 2'b11
	} adcsc_fsm_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} adcsc_apb_t;

endpackage

/* verification/adcsc_core_model.sv */
/*
 Model of the analog core and the on-chip trigger sources that sit
 beside the converter sequencing control.
 Assumes the control samples the result while conv_active_in is high.
*/
`timescale 1ns/10ps
`default_nettype none

module adcsc_core_model (
	// clock
	input  wire logic       clk_in,
	// control side and bench requests
	input  wire logic       conv_active_in,
	input  wire logic [9:0] next_result_in,
	input  wire logic [7:0] trig_req_in,
	// towards the control
	output logic [9:0]      conv_data_out,
	output logic [7:0]      trig_flags_out
);
	logic [9:0] held_r = 10'h000;
	logic       act_r  = 1'b0;

	initial begin
		conv_data_out  = 10'h155;
		trig_flags_out = 8'h00;
	end

	always @(posedge clk_in) begin
		act_r          <= conv_active_in;
		trig_flags_out <= trig_req_in;
		if (conv_active_in && !act_r) begin
			held_r        <= next_result_in;
			conv_data_out <= next_result_in;
		end else if (conv_active_in) begin
			conv_data_out <= held_r;
		end else begin
			// no valid sample outside a run: keep the lines moving
			conv_data_out <= ~conv_data_out;
		end
	end
endmodule

`default_nettype wire

/* verification/tb_adc_sequencing_control.sv */
/*
 Self-checking bench of the converter sequencing control.
 Assumes the core model and the design files are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_params.svh"

module tb_adc_sequencing_control
	import adcsc_pkg::*;
;
	// ------------------------------------------------
	// signals
	// ------------------------------------------------
	logic        sys_clk, rst, pready, pslverr, gie, ack, irq;
	logic        power, active, act_q, serr;
	adcsc_apb_t  bus;
	logic [31:0] prdata, rd;
	logic [7:0]  flags, trig_req, raw, pout, pv, pdo;
	logic [4:0]  chan;
	logic [1:0]  refs;
	logic [9:0]  cdata, dval, old;
	int          err_count = 0, checks = 0, act_n = 0, starts = 0;
	int          cyc = 0, a0;

	adcsc_top dut (
		.sys_clk_in(sys_clk), .rst_in(rst), .apb_in(bus),
		.prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .global_irq_enable_in(gie),
		.irq_ack_in(ack), .irq_out(irq), .trig_flags_in(flags),
		.conv_data_in(cdata), .adc_power_out(power),
		.conv_active_out(active), .channel_select_out(chan),
		.reference_select_out(refs), .pin_raw_in(raw),
		.port_pin_out(pout), .pin_input_disable_out(pdo)
	);

	adcsc_core_model core (
		.clk_in(sys_clk), .conv_active_in(active),
		.next_result_in(dval), .trig_req_in(trig_req),
		.conv_data_out(cdata), .trig_flags_out(flags)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// run length and start counters, hang guard
	always @(posedge sys_clk) begin
		cyc    <= cyc + 1;
		act_q  <= active;
		act_n  <= act_n + int'(active);
		starts <= starts + int'(active && !act_q);
		if (cyc == 40000) begin
			err_count++;
			stop_test();
		end
	end

	// ------------------------------------------------
	// tasks
	// ------------------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
	                   input logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
		         pwdata: d};
		@(posedge sys_clk);
		bus.penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd   = prdata;
		serr = pslverr;
		bus.psel    <= 1'b0;
		bus.penable <= 1'b0;
	endtask

	function automatic int div_of(input logic [2:0] c);
		return (c == 3'h0) ? 2 : (1 << c);
	endfunction

	function automatic logic [31:0] res_b(input logic [9:0] r,
	                                      input logic lft, hi);
		logic [15:0] w;
		w = lft ? {r, 6'h00} : {6'h00, r};
		return {24'h0, hi ? w[15:8] : w[7:0]};
	endfunction

	task automatic rdres(input logic [9:0] r, input logic lft);
		apb(1'b0, `ADCSC_OFF_RESLO, 32'h0);
		chk("result low", rd, res_b(r, lft, 1'b0));
		apb(1'b0, `ADCSC_OFF_RESHI, 32'h0);
		chk("result high", rd, res_b(r, lft, 1'b1));
	endtask

	task automatic conv(input logic [7:0] ctl, input int n);
		int b;
		b = act_n;
		apb(1'b1, `ADCSC_OFF_CTLA, {24'h0, ctl});
		wait (active === 1'b1);
		apb(1'b0, `ADCSC_OFF_CTLA, 32'h0);
		chk("start while busy", rd[6], 1);
		wait (active === 1'b0);
		repeat (2) @(posedge sys_clk);
		chk("run length", act_n - b, n * div_of(ctl[2:0]));
	endtask

	// ------------------------------------------------
	// sequence
	// ------------------------------------------------
	initial begin
		bus = '0;
		rst = 1'b1;
		{gie, ack, trig_req, raw, dval} = '0;
		void'($urandom(66));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		for (int a = 0; a <= 'h18; a += 4) begin
			apb(1'b0, 8'(a), 32'h0);
			chk("reset read", rd, 32'h0);
			chk("bus error", serr, a == 'h18);
		end
		pv = 8'($urandom);
		raw <= 8'($urandom);
		apb(1'b1, `ADCSC_OFF_PDIS, {24'h0, pv});
		apb(1'b0, `ADCSC_OFF_PDIS, 32'h0);
		chk("pin disable", rd, pv);
		chk("pin disable out", pdo, pv);
		chk("port pins", pout, raw & ~pv);
		gie <= 1'b1;
		for (int p = 0; p < 8; p++) begin
			apb(1'b1, `ADCSC_OFF_CTLA, 32'h0);
			for (int k = 0; k < 2; k++) begin
				dval <= 10'($urandom);
				conv(8'hD8 | 8'(p), k ? 13 : 25);
				apb(1'b0, `ADCSC_OFF_CTLA, 32'h0);
				chk("control after run", rd, 32'h98 | p);
				chk("irq", irq, 1);
				rdres(dval, 1'b0);
			end
		end
		gie <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("irq masked", irq, 0);
		gie <= 1'b1;
		ack <= 1'b1;
		@(posedge sys_clk);
		ack <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("irq after ack", irq, 0);
		apb(1'b1, `ADCSC_OFF_CTLA, 32'h0);
		dval <= 10'($urandom);
		conv(8'hC8, 25);
		apb(1'b0, `ADCSC_OFF_RESLO, 32'h0);
		old = dval;
		dval <= 10'($urandom);
		conv(8'hD8, 13);
		apb(1'b0, `ADCSC_OFF_RESHI, 32'h0);
		chk("locked high", rd, res_b(old, 1'b0, 1'b1));
		rdres(old, 1'b0);
		dval <= 10'($urandom);
		conv(8'hD8, 13);
		rdres(dval, 1'b0);
		apb(1'b1, `ADCSC_OFF_ISEL, 32'hE5);
		rdres(dval, 1'b1);
		// high byte alone must not lock, so the second run lands
		repeat (2) begin
			dval <= 10'($urandom);
			conv(8'hD8, 13);
			apb(1'b0, `ADCSC_OFF_RESHI, 32'h0);
			chk("high only", rd, res_b(dval, 1'b1, 1'b1));
		end
		apb(1'b1, `ADCSC_OFF_CTLA, 32'hD7);
		wait (active === 1'b1);
		apb(1'b1, `ADCSC_OFF_ISEL, 32'h43);
		repeat (2) @(posedge sys_clk);
		chk("held selection", {refs, chan}, 7'h65);
		apb(1'b1, `ADCSC_OFF_CTLA, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk("abort", {power, active}, 0);
		chk("idle selection", {refs, chan}, 7'h23);
		apb(1'b0, `ADCSC_OFF_CTLA, 32'h0);
		chk("abort control", rd, 0);
		apb(1'b1, `ADCSC_OFF_CTLA, 32'hA8);
		for (int t = 1; t < 8; t++) begin
			apb(1'b1, `ADCSC_OFF_CTLB, 32'h40 | t);
			a0 = starts;
			trig_req <= 8'(1 << (t % 7 + 1));
			repeat (10) @(posedge sys_clk);
			chk("other source", starts - a0, 0);
			trig_req <= 8'(1 << t);
			wait (active === 1'b1);
			wait (active === 1'b0);
			repeat (2) @(posedge sys_clk);
			apb(1'b0, `ADCSC_OFF_CTLA, 32'h0);
			chk("triggered", rd, 32'hB8);
			apb(1'b1, `ADCSC_OFF_CTLA, 32'hB8);
			apb(1'b0, `ADCSC_OFF_CTLA, 32'h0);
			chk("flag cleared", rd, 32'hA8);
			trig_req <= 8'h00;
		end
		apb(1'b0, `ADCSC_OFF_CTLB, 32'h0);
		chk("control b", rd, 32'h47);
		apb(1'b1, `ADCSC_OFF_CTLB, 32'h1);
		trig_req <= 8'h08;
		a0 = starts;
		apb(1'b1, `ADCSC_OFF_CTLB, 32'h3);
		repeat (10) @(posedge sys_clk);
		chk("source switch", starts - a0, 1);
		wait (active === 1'b0);
		trig_req <= 8'h00;
		a0 = starts;
		apb(1'b1, `ADCSC_OFF_CTLB, 32'h0);
		repeat (40) @(posedge sys_clk);
		chk("free select", starts - a0, 0);
		apb(1'b1, `ADCSC_OFF_CTLA, 32'hF0);
		repeat (2) begin
			apb(1'b1, `ADCSC_OFF_CTLA, 32'hB0);
			repeat (40) @(posedge sys_clk);
			apb(1'b0, `ADCSC_OFF_CTLA, 32'h0);
			chk("free running", rd, 32'hF0);
		end
		apb(1'b1, `ADCSC_OFF_CTLA, 32'h0);
		stop_test();
	end
endmodule

`default_nettype wire
